// ==== chan_pkg.sv ====
// shared constants for the expansion channel master
package chan_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int IRQ_N = 6;
  localparam int DMA_N = 3;
  localparam int GRANT_N = 4;
  localparam int SYS_CLK_MHZ = 100;
  localparam int TIMEBASE_PERIOD_PS = 70000;
  localparam int TIMEBASE_HALF_CYC = (TIMEBASE_PERIOD_PS / 2) / (1000000 / SYS_CLK_MHZ);
  localparam int BUS_DIV = 3;
  localparam int BUS_HIGH_PHASES = 1;
  localparam int MEM_CLOCKS = 4;
  localparam int IO_CLOCKS = 5;
  localparam int DMA_CLOCKS = 5;
  localparam int REFRESH_CLOCKS = 4;
  localparam int REFRESH_PERIOD = 72;
  localparam int WAIT_LIMIT = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int REQ_W = 1 + 1 + ADDR_W + DATA_W;
  localparam logic [7:0] NO_DATA = 8'h00;
  typedef enum logic [1:0] {IDLE, ADDR, CMD, DONE} phase_t;
endpackage

// ==== chan_fifo.sv ====
// synchronous valid/ready fifo
`timescale 1ns/10ps
`default_nettype none
module chan_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [WIDTH-1:0] rd_word;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire empty = (wr_ptr == rd_ptr);
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== chan_clocks.sv ====
// fast timebase and divide-by-three bus clock generator
`timescale 1ns/10ps
`default_nettype none
module chan_clocks #(
  parameter int HALF_CYC = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic fast_timebase,
  output logic bus_clk,
  output logic bus_rise,
  output logic bus_fall
);
  import chan_pkg::*;
  initial begin
    if (HALF_CYC < 1) $error("half period must be at least one cycle");
  end
  logic [7:0] half_cnt;
  logic [1:0] phase;
  wire half_done = (half_cnt == 8'(HALF_CYC - 1));
  wire tb_rise = half_done && !fast_timebase;
  wire [1:0] next_phase = (phase == 2'(BUS_DIV - 1)) ? 2'd0 : phase + 2'd1;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      half_cnt <= '0;
      fast_timebase <= 1'b0;
      phase <= '0;
      bus_clk <= 1'b0;
      bus_rise <= 1'b0;
      bus_fall <= 1'b0;
    end else begin
      half_cnt <= half_done ? 8'd0 : half_cnt + 8'd1;
      if (half_done) fast_timebase <= !fast_timebase;
      if (tb_rise) phase <= next_phase;
      bus_rise <= tb_rise && next_phase == 2'd0;
      bus_fall <= tb_rise && next_phase == 2'(BUS_HIGH_PHASES);
      if (tb_rise) bus_clk <= (next_phase < 2'(BUS_HIGH_PHASES));
    end
  end
endmodule
`default_nettype wire

// ==== chan_master.sv ====
// system-board side of the 8-bit expansion channel
`timescale 1ns/10ps
`default_nettype none
module chan_master #(
  parameter int DEPTH = chan_pkg::FIFO_DEPTH,
  parameter int WAIT_MAX = chan_pkg::WAIT_LIMIT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_low,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_is_io,
  input wire logic req_write,
  input wire logic [chan_pkg::ADDR_W-1:0] req_addr,
  input wire logic [chan_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [chan_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic dma_cycle_ok,
  input wire logic [chan_pkg::ADDR_W-1:0] dma_addr,
  input wire logic dma_to_mem,
  input wire logic [15:0] dma_count,
  output logic fast_timebase,
  output logic bus_clk,
  output logic channel_reset_out,
  output logic [chan_pkg::ADDR_W-1:0] addr_bus,
  input wire logic [chan_pkg::DATA_W-1:0] byte_bus_in,
  output logic [chan_pkg::DATA_W-1:0] byte_bus_out,
  output logic byte_bus_oe,
  output logic addr_latch,
  output logic io_read_n,
  output logic io_write_n,
  output logic mem_read_n,
  output logic mem_write_n,
  output logic dma_owns_bus,
  output logic [chan_pkg::GRANT_N-1:0] dma_grant_n,
  output logic term_count,
  input wire logic channel_error_n,
  input wire logic channel_wait_release,
  input wire logic [chan_pkg::IRQ_N-1:0] int_request,
  input wire logic [chan_pkg::DMA_N-1:0] dma_request,
  output logic nmi,
  output logic [2:0] int_level,
  output logic int_pending,
  output logic wait_overrun
);
  import chan_pkg::*;
  initial begin
    if (DEPTH < 2) $error("fifo too shallow");
    if (WAIT_MAX < 1) $error("wait limit must be positive");
  end

  ////////////////////////////////////////////////////////////////
  // clocks and request buffer
  logic bus_rise;
  logic bus_fall;
  chan_clocks #(.HALF_CYC(TIMEBASE_HALF_CYC)) u_clocks (
    .clk(clk),
    .rst_n(rst_n),
    .fast_timebase(fast_timebase),
    .bus_clk(bus_clk),
    .bus_rise(bus_rise),
    .bus_fall(bus_fall)
  );
  logic [REQ_W-1:0] q_data;
  logic q_valid;
  logic q_pop;
  chan_fifo #(.WIDTH(REQ_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data({req_is_io, req_write, req_addr, req_wdata}),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_pop)
  );
  wire q_io = q_data[REQ_W-1];
  wire q_wr = q_data[REQ_W-2];
  wire [ADDR_W-1:0] q_addr = q_data[DATA_W +: ADDR_W];
  wire [DATA_W-1:0] q_wdata = q_data[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////
  // reset drive, error and interrupt ranking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_reset_out <= 1'b1;
    end else if (bus_fall) begin
      channel_reset_out <= power_low;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmi <= 1'b0;
    end else begin
      nmi <= !channel_error_n;
    end
  end
  logic [2:0] next_level;
  always_comb begin
    next_level = 3'd0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (int_request[i]) next_level = 3'(i);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_level <= 3'd0;
      int_pending <= 1'b0;
    end else begin
      int_level <= next_level;
      int_pending <= |int_request;
    end
  end

  ////////////////////////////////////////////////////////////////
  // cycle arbitration: refresh, then dma 1..3, then processor
  logic [6:0] refresh_cnt;
  logic refresh_due;
  wire refresh_tick = bus_rise && refresh_cnt == 7'(REFRESH_PERIOD - 1);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refresh_cnt <= '0;
    end else if (bus_rise) begin
      refresh_cnt <= refresh_tick ? 7'd0 : refresh_cnt + 7'd1;
    end
  end
  logic [1:0] dma_pick;
  always_comb begin
    dma_pick = 2'd0;
    for (int i = DMA_N - 1; i >= 0; i--) begin
      if (dma_request[i]) dma_pick = 2'(i + 1);
    end
  end

  typedef enum logic [1:0] {K_CPU, K_DMA, K_REF} kind_t;
  phase_t state;
  kind_t kind;
  logic [2:0] clk_cnt;
  logic [2:0] clk_need;
  logic [1:0] chan;
  logic cyc_io;
  logic cyc_wr;
  logic [3:0] wait_cnt;
  logic [15:0] dma_left [DMA_N];
  wire wait_hold = !channel_wait_release && state == CMD;
  wire cmd_last = bus_rise && state == CMD && !wait_hold
    && clk_cnt == clk_need - 3'd2;
  wire start_ref = refresh_due || refresh_tick;
  wire start_dma = dma_pick != 2'd0 && dma_cycle_ok;
  wire start_cpu = q_valid;
  wire start_any = state == IDLE && bus_rise && (start_ref || start_dma || start_cpu);
  wire [1:0] cur_idx = chan - 2'd1;
  wire cur_last = kind == K_DMA && dma_left[cur_idx] == 16'h0001;
  assign q_pop = state == DONE && bus_rise && kind == K_CPU;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refresh_due <= 1'b0;
    end else if (refresh_tick && !(state == IDLE && bus_rise)) begin
      refresh_due <= 1'b1;
    end else if (start_any && start_ref) begin
      refresh_due <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= IDLE;
      kind <= K_CPU;
      clk_cnt <= '0;
      clk_need <= '0;
      chan <= '0;
      cyc_io <= 1'b0;
      cyc_wr <= 1'b0;
    end else if (bus_rise) begin
      case (state)
        IDLE: begin
          clk_cnt <= 3'd0;
          if (start_ref) begin
            state <= ADDR;
            kind <= K_REF;
            chan <= 2'd0;
            cyc_io <= 1'b0;
            cyc_wr <= 1'b0;
            clk_need <= 3'(REFRESH_CLOCKS);
          end else if (start_dma) begin
            state <= ADDR;
            kind <= K_DMA;
            chan <= dma_pick;
            cyc_io <= 1'b0;
            cyc_wr <= dma_to_mem;
            clk_need <= 3'(DMA_CLOCKS);
          end else if (start_cpu) begin
            state <= ADDR;
            kind <= K_CPU;
            chan <= 2'd0;
            cyc_io <= q_io;
            cyc_wr <= q_wr;
            clk_need <= q_io ? 3'(IO_CLOCKS) : 3'(MEM_CLOCKS);
          end
        end
        ADDR: begin
          state <= CMD;
          clk_cnt <= 3'd1;
        end
        CMD: begin
          if (!wait_hold) begin
            clk_cnt <= clk_cnt + 3'd1;
            if (clk_cnt == clk_need - 3'd2) state <= DONE;
          end
        end
        DONE: state <= IDLE;
        default: state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_cnt <= '0;
      wait_overrun <= 1'b0;
    end else if (bus_rise) begin
      wait_cnt <= wait_hold ? wait_cnt + 4'd1 : 4'd0;
      wait_overrun <= wait_hold && wait_cnt >= 4'(WAIT_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////
  // dma transfer counters and terminal count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      term_count <= 1'b0;
    end else begin
      term_count <= bus_rise && state == DONE && cur_last;
    end
  end
  for (genvar g = 0; g < DMA_N; g++) begin : g_cnt
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        dma_left[g] <= '0;
      end else if (bus_rise && state == IDLE && start_dma && !start_ref
          && dma_pick == 2'(g + 1) && dma_left[g] == 16'h0000) begin
        dma_left[g] <= dma_count;
      end else if (bus_rise && state == DONE && kind == K_DMA && cur_idx == 2'(g)
          && dma_left[g] != 16'h0000) begin
        dma_left[g] <= dma_left[g] - 16'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // channel pin drive
  wire active = state == CMD;
  wire owner_dma = kind != K_CPU && state != IDLE;
  wire [ADDR_W-1:0] next_addr = kind == K_CPU ? q_addr :
    kind == K_DMA ? dma_addr : {{(ADDR_W-7){1'b0}}, refresh_cnt};
  wire drive_data = state != IDLE && cyc_wr && kind == K_CPU;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_bus <= '0;
      addr_latch <= 1'b0;
      dma_owns_bus <= 1'b0;
      dma_grant_n <= '1;
      io_read_n <= 1'b1;
      io_write_n <= 1'b1;
      mem_read_n <= 1'b1;
      mem_write_n <= 1'b1;
      byte_bus_out <= NO_DATA;
      byte_bus_oe <= 1'b0;
    end else begin
      if (state == ADDR) addr_bus <= next_addr;
      addr_latch <= state == ADDR && kind == K_CPU && !bus_clk;
      dma_owns_bus <= owner_dma && kind == K_DMA;
      for (int i = 0; i < GRANT_N; i++) begin
        dma_grant_n[i] <= !(state != IDLE && kind != K_CPU && chan == 2'(i));
      end
      io_read_n <= !(active && cyc_io && !cyc_wr);
      io_write_n <= !(active && cyc_io && cyc_wr);
      mem_read_n <= !(active && !cyc_io && !cyc_wr && kind != K_REF);
      mem_write_n <= !(active && !cyc_io && cyc_wr);
      byte_bus_out <= q_wdata;
      byte_bus_oe <= drive_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= NO_DATA;
    end else begin
      rsp_valid <= q_pop && !q_wr;
      if (cmd_last) rsp_rdata <= byte_bus_in;
    end
  end
endmodule
`default_nettype wire

// ==== chan_master_assertions.sv ====
// concurrent checks on the channel master ports
`timescale 1ns/10ps
`default_nettype none
module chan_checks (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fast_timebase,
  input wire logic bus_clk,
  input wire logic addr_latch,
  input wire logic io_read_n,
  input wire logic io_write_n,
  input wire logic mem_read_n,
  input wire logic mem_write_n,
  input wire logic dma_owns_bus,
  input wire logic [3:0] dma_grant_n,
  input wire logic term_count,
  input wire logic channel_error_n,
  input wire logic channel_wait_release,
  input wire logic [5:0] int_request,
  input wire logic [2:0] int_level,
  input wire logic int_pending,
  input wire logic nmi
);
  wire logic [3:0] strb = {io_read_n, io_write_n, mem_read_n, mem_write_n};
  wire logic cmd = strb != 4'hF;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  tbase_half_a: assert property ($changed(fast_timebase) |=>
    $stable(fast_timebase)[*2] ##1 $changed(fast_timebase)) else $error("timebase half period");
  bus_high_a: assert property ($rose(bus_clk) |-> bus_clk[*6] ##1 !bus_clk)
    else $error("bus clock high phase");
  bus_low_a: assert property ($fell(bus_clk) |-> !bus_clk[*8])
    else $error("bus clock low phase");
  one_strobe_a: assert property (!dma_owns_bus |-> $onehot0(~strb))
    else $error("two strobes at once");
  one_grant_a: assert property ($onehot0(~dma_grant_n)) else $error("two grants");
  latch_phase_a: assert property (addr_latch |-> !dma_owns_bus && !cmd)
    else $error("latch out of place");
  wait_hold_a: assert property (cmd && !channel_wait_release |=> cmd)
    else $error("strobe ended in wait");
  nmi_follow_a: assert property (nmi == !$past(channel_error_n))
    else $error("nmi not following error");
  irq_rank_a: assert property (int_request[0] |=> int_pending && int_level == 3'h0)
    else $error("top line not chosen");
  tc_pulse_a: assert property (term_count |=> !term_count) else $error("tc too long");
  cover property (!dma_grant_n[0]);
  cover property (term_count);
  cover property (cmd && !channel_wait_release);
endmodule
bind chan_master chan_checks chk (.clk, .rst_n, .fast_timebase, .bus_clk, .addr_latch,
  .io_read_n, .io_write_n, .mem_read_n, .mem_write_n, .dma_owns_bus, .dma_grant_n,
  .term_count, .channel_error_n, .channel_wait_release, .int_request, .int_level,
  .int_pending, .nmi);
`default_nettype wire

// ==== adapter_model.sv ====
// adapter card model with byte store and wait stretch
`timescale 1ns/10ps
`default_nettype none
module adapter_model (
  input wire logic clk,
  input wire logic [19:0] addr_bus,
  input wire logic [7:0] byte_bus_out,
  input wire logic byte_bus_oe,
  input wire logic io_read_n,
  input wire logic io_write_n,
  input wire logic mem_read_n,
  input wire logic mem_write_n,
  input wire logic dma_owns_bus,
  input wire logic [7:0] stall,
  output logic [7:0] byte_bus_in,
  output logic channel_wait_release
);
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic cmd_q = 1'b0;
  wire logic io_ok = !dma_owns_bus;
  wire logic rd = !mem_read_n || (!io_read_n && io_ok);
  wire logic wr = !mem_write_n || (!io_write_n && io_ok);
  wire logic cmd = rd || wr;
  assign byte_bus_in = byte_bus_oe ? byte_bus_out : rd ? mem[addr_bus[7:0]] : ~last;
  assign channel_wait_release = cnt == 8'h00 && !(cmd && !cmd_q && stall != 8'h00);
  always @(posedge clk) begin
    cmd_q <= cmd;
    last <= byte_bus_in;
    if (wr) mem[addr_bus[7:0]] <= byte_bus_out;
    if (cmd && !cmd_q) cnt <= stall;
    else if (cnt != 8'h00) cnt <= cnt - 8'h01;
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the channel master
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import chan_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, power_low = 1'b0, req_valid = 1'b0, req_is_io = 1'b0;
  logic req_write = 1'b0, dma_cycle_ok = 1'b0, dma_to_mem = 1'b0, channel_error_n = 1'b1;
  logic [19:0] req_addr = 20'h0_0000, dma_addr = 20'h0_0000, addr_bus;
  logic [7:0] req_wdata = 8'h00, stall = 8'h00, byte_bus_in, byte_bus_out, rsp_rdata;
  logic [15:0] dma_count = 16'h0001;
  logic [5:0] int_request = 6'h00;
  logic [2:0] dma_request = 3'h0, int_level;
  logic [3:0] dma_grant_n;
  logic req_ready, rsp_valid, fast_timebase, bus_clk, channel_reset_out, byte_bus_oe;
  logic addr_latch, io_read_n, io_write_n, mem_read_n, mem_write_n, dma_owns_bus;
  logic term_count, channel_wait_release, nmi, int_pending, wait_overrun;
  int n_errors = 0, cmp_count = 0;
  wire logic [3:0] strb = {io_read_n, io_write_n, mem_read_n, mem_write_n};
  chan_master uut (.*);
  adapter_model card (.*);
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic push(input logic io, input logic wr, input logic [19:0] a, input logic [7:0] d);
    req_is_io <= io;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    do @(negedge clk); while (!req_ready);
    @(posedge clk);
  endtask
  task automatic xfer(input logic io, input logic wr, input logic [19:0] a, input logic [7:0] d,
                      input int len);
    int n;
    logic [1:0] k;
    n = 0;
    k = {io, !wr};
    push(io, wr, a, d);
    req_valid <= 1'b0;
    while ((strb[k] || !dma_grant_n[0]) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(addr_bus, a);
    if (wr) chk({byte_bus_oe, byte_bus_out}, {1'b1, d});
    n = 0;
    while (!strb[k] && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(n, len);
    n = 0;
    while (!wr && !rsp_valid && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (!wr) chk(rsp_rdata, d);
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_cycles();
    xfer(1'b0, 1'b1, 20'hA_5123, 8'h3C, 36);
    xfer(1'b0, 1'b0, 20'hA_5123, 8'h3C, 36);
    xfer(1'b1, 1'b1, 20'h0_0341, 8'hC5, 54);
    xfer(1'b1, 1'b0, 20'h0_0341, 8'hC5, 54);
    stall <= 8'h2D;
    xfer(1'b0, 1'b0, 20'hA_5123, 8'h3C, 72);
    stall <= 8'h00;
  endtask
  task automatic t_fifo();
    int acc;
    acc = 0;
    for (int i = 0; i < 30; i++) begin
      push(1'b0, 1'b1, 20'hB_0000 + 20'(i), 8'(i));
      acc++;
      if (i == 29) req_valid <= 1'b0;
    end
    chk(acc, 30);
    repeat (3200) @(posedge clk);
    chk(req_ready, 1'b1);
  endtask
  task automatic t_irq();
    for (int i = 0; i < 6; i++) begin
      int_request <= 6'h01 << i;
      repeat (3) @(posedge clk);
      chk({int_pending, int_level}, {1'b1, 3'(i)});
    end
    int_request <= 6'h24;
    repeat (3) @(posedge clk);
    chk(int_level, 3'h2);
    int_request <= 6'h00;
    channel_error_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(nmi, 1'b1);
    channel_error_n <= 1'b1;
  endtask
  task automatic t_dma();
    int n;
    n = 0;
    dma_addr <= 20'hC_0000;
    dma_to_mem <= 1'b1;
    dma_cycle_ok <= 1'b1;
    dma_request <= 3'h5;
    while (dma_grant_n[3:1] == 3'h7 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(dma_grant_n, 4'hD);
    chk(dma_owns_bus, 1'b1);
    @(posedge clk);
    dma_request <= 3'h4;
    n = 0;
    while (!term_count && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk(term_count, 1'b1);
    @(posedge clk);
    dma_request <= 3'h0;
    dma_cycle_ok <= 1'b0;
    repeat (200) @(posedge clk);
  endtask
  task automatic t_refresh();
    int n;
    n = 0;
    while (dma_grant_n[0] && n < 3000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (!dma_grant_n[0] && n < 3000) @(negedge clk);
    while (dma_grant_n[0] && n < 3000) begin
      @(negedge clk);
      n++;
    end
    while (!dma_grant_n[0] && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(n, 1296);
    @(posedge clk);
  endtask
  task automatic t_power();
    int n;
    n = 0;
    power_low <= 1'b1;
    while (!channel_reset_out && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk({channel_reset_out, bus_clk}, 2'h2);
    chk(wait_overrun, 1'b0);
    @(posedge clk);
    power_low <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    chk({channel_reset_out, strb, dma_grant_n}, 9'h1FF);
    @(posedge clk);
    rst_n <= 1'b1;
    t_cycles();
    t_fifo();
    t_irq();
    t_dma();
    t_refresh();
    t_power();
    test_done();
  end
  initial begin
    #800000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
